/* File: verilog/scidc_params.svh */
`ifndef SCIDC_PARAMS_SVH
`define SCIDC_PARAMS_SVH

// ************************************************************
// widths and reset values
// ************************************************************
`define SCIDC_VEC_W 8
`define SCIDC_SRC_N 6
`define SCIDC_VEC_RST 8'h00
`define SCIDC_SRC_RST 6'h00

// ************************************************************
// vector field positions
// ************************************************************
`define SCIDC_VAR_LO 1
`define SCIDC_VAR_HI 3

// ************************************************************
// register pointer of the vector readback register
// ************************************************************
`define SCIDC_PTR_VEC 3'h2

// ************************************************************
// snooped opcodes and vector codes
// ************************************************************
`define SCIDC_OP_PREFIX 8'hed
`define SCIDC_OP_RETURN 8'h4d
`define SCIDC_CODE_IDLE 3'h3
`define SCIDC_CODE_A_RX 3'h6
`define SCIDC_CODE_A_TX 3'h4
`define SCIDC_CODE_A_EXT 3'h5
`define SCIDC_CODE_B_RX 3'h2
`define SCIDC_CODE_B_TX 3'h0
`define SCIDC_CODE_B_EXT 3'h1

`endif

/* File: verilog/scidc_pkg.sv */
`include "scidc_params.svh"

package scidc_pkg;

    // ************************************************************
    // host bus carrier
    // ************************************************************
    typedef struct packed {
        logic opcode_fetch_cycle_n;
        logic io_request_n;
        logic rd;
        logic chan_b;
        logic [2:0] ptr;
        logic vector_base_write_reg;
        logic return_cmd;
        logic [`SCIDC_VEC_W-1:0] data;
    } scidc_bus_type;

    // ************************************************************
    // opcode snoop states
    // ************************************************************
    typedef enum logic [0:0] {
        SCIDC_SNP_IDLE = 1'b0,
        SCIDC_SNP_PREFIX = 1'b1
    } scidc_snoop_type;

endpackage

/* File: verilog/scidc_irq_chain.sv */
`include "scidc_params.svh"

// How it works
// - without status modifies vector, readback returns the stored vector base
// - with status modifies vector, middle bits follow highest pending source
// - only bits three to one vary; other bits come from the base
// - nothing pending: modified vector carries bits three to one as 011
// - readback answers only on channel B accesses
// - service request drives the active-low interrupt request low while chain input is high
// - idle device passes chain input level to chain output
// - pending status is frozen while opcode fetch is low
// - on acknowledge, enabled requester drives vector and sets in-service
// - return-from-handler is opcode pair ED then 4D, snooped on fetches
// - after ED, chain output ignores pending unacknowledged interrupts
// - 4D after ED clears in-service latch of device with input high
// - written return command also clears the in-service latch
// - six internal sources in fixed precedence, index zero highest
// - higher source preempts lower; each return clears only the top latch
module scidc_irq_chain
    import scidc_pkg::*;
(
    input logic core_clk,
    input logic rst,
    input scidc_bus_type host_bus,
    input logic status_modifies_vector,
    input logic [`SCIDC_SRC_N-1:0] src_pending,
    input logic chain_priority_in,
    output logic chain_priority_out,
    output logic int_req_n,
    output logic [`SCIDC_VEC_W-1:0] data_out,
    output logic data_oe
);

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic [`SCIDC_SRC_N-1:0] top_one(
        input logic [`SCIDC_SRC_N-1:0] v
    );
        top_one = v & (~v + `SCIDC_SRC_N'(1));
    endfunction

    function automatic logic [2:0] code_of(
        input logic [`SCIDC_SRC_N-1:0] one
    );
        logic [2:0] c;
        c = `SCIDC_CODE_IDLE;
        case (one)
            6'h01: c = `SCIDC_CODE_A_RX;
            6'h02: c = `SCIDC_CODE_A_TX;
            6'h04: c = `SCIDC_CODE_A_EXT;
            6'h08: c = `SCIDC_CODE_B_RX;
            6'h10: c = `SCIDC_CODE_B_TX;
            6'h20: c = `SCIDC_CODE_B_EXT;
            default: c = `SCIDC_CODE_IDLE;
        endcase
        code_of = c;
    endfunction

    function automatic logic [`SCIDC_VEC_W-1:0] build_vec(
        input logic [`SCIDC_VEC_W-1:0] base,
        input logic modify,
        input logic [2:0] code
    );
        logic [`SCIDC_VEC_W-1:0] v;
        v = base;
        if (modify) begin
            v[`SCIDC_VAR_HI:`SCIDC_VAR_LO] = code;
        end
        build_vec = v;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic [`SCIDC_SRC_N-1:0] pend;
    logic [`SCIDC_SRC_N-1:0] ius;
    logic [`SCIDC_VEC_W-1:0] vec_base;
    logic [`SCIDC_VEC_W-1:0] op_byte;
    logic ack_q;
    logic plain_q;
    logic ack_own;
    scidc_snoop_type snoop;
    scidc_snoop_type next_snoop;

    // ************************************************************
    // decoding
    // ************************************************************
    wire fetch = !host_bus.opcode_fetch_cycle_n;
    wire ack = fetch && !host_bus.io_request_n;
    wire plain = fetch && host_bus.io_request_n;
    wire ack_start = ack && !ack_q;
    wire fetch_end = plain_q && !plain;
    wire read_vec = host_bus.rd && host_bus.chan_b &&
        (host_bus.ptr == `SCIDC_PTR_VEC);
    wire prefix_seen = snoop == SCIDC_SNP_PREFIX;

    logic [`SCIDC_SRC_N-1:0] blocked;
    genvar gi;
    generate
        for (gi = 0; gi < `SCIDC_SRC_N; gi = gi + 1) begin : g_blk
            assign blocked[gi] = |ius[gi:0];
        end
    endgenerate

    wire [`SCIDC_SRC_N-1:0] req_vec = pend & ~blocked;
    wire req_any = |req_vec;
    wire [`SCIDC_SRC_N-1:0] win = chain_priority_in ?
        top_one(req_vec) : `SCIDC_SRC_RST;
    wire win_any = |win;
    wire [`SCIDC_VEC_W-1:0] rd_value =
        build_vec(vec_base, status_modifies_vector, code_of(top_one(pend)));
    wire [`SCIDC_VEC_W-1:0] ack_value =
        build_vec(vec_base, status_modifies_vector, code_of(win));
    wire ret_snoop = fetch_end && prefix_seen &&
        (op_byte == `SCIDC_OP_RETURN) && chain_priority_in;
    wire ret_any = ret_snoop || host_bus.return_cmd;
    wire [`SCIDC_SRC_N-1:0] clr = ret_any ? top_one(ius) : `SCIDC_SRC_RST;
    wire [`SCIDC_SRC_N-1:0] set = ack_start ? win : `SCIDC_SRC_RST;
    wire chain_busy = prefix_seen ? |ius : |(pend | ius);
    wire next_chain_out = chain_priority_in && !chain_busy;
    wire next_oe = read_vec || (ack && (ack_start ? win_any : ack_own));

    always_comb begin
        next_snoop = snoop;
        if (fetch_end) begin
            if (op_byte == `SCIDC_OP_PREFIX) begin
                next_snoop = SCIDC_SNP_PREFIX;
            end else begin
                next_snoop = SCIDC_SNP_IDLE;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pend <= `SCIDC_SRC_RST;
        end else if (!fetch) begin
            pend <= src_pending;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ius <= `SCIDC_SRC_RST;
        end else begin
            ius <= (ius | set) & ~clr;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            vec_base <= `SCIDC_VEC_RST;
        end else if (host_bus.vector_base_write_reg) begin
            vec_base <= host_bus.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            op_byte <= `SCIDC_VEC_RST;
            plain_q <= 1'b0;
            ack_q <= 1'b0;
            snoop <= SCIDC_SNP_IDLE;
        end else begin
            if (plain) begin
                op_byte <= host_bus.data;
            end
            plain_q <= plain;
            ack_q <= ack;
            snoop <= next_snoop;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_own <= 1'b0;
        end else if (!ack) begin
            ack_own <= 1'b0;
        end else if (ack_start) begin
            ack_own <= win_any;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            chain_priority_out <= 1'b0;
            int_req_n <= 1'b1;
            data_out <= `SCIDC_VEC_RST;
            data_oe <= 1'b0;
        end else begin
            chain_priority_out <= next_chain_out;
            int_req_n <= !(chain_priority_in && req_any);
            data_oe <= next_oe;
            if (ack_start) begin
                data_out <= ack_value;
            end else if (read_vec) begin
                data_out <= rd_value;
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_plain_vec;
        @(posedge core_clk) disable iff (rst)
        read_vec && !ack_start && !status_modifies_vector |=>
            data_out == $past(vec_base);
    endproperty
    a_plain_vec: assert property (p_plain_vec)
        else $error("readback differs from stored vector base");

    property p_mod_vec;
        @(posedge core_clk) disable iff (rst)
        read_vec && !ack_start && status_modifies_vector && pend != 6'h00
        |=> data_out[3:1] == code_of(top_one($past(pend)));
    endproperty
    a_mod_vec: assert property (p_mod_vec)
        else $error("modified vector does not follow top pending source");

    property p_fixed_bits;
        @(posedge core_clk) disable iff (rst)
        read_vec && !ack_start |=>
            data_out[7:4] == $past(vec_base[7:4]) &&
            data_out[0] == $past(vec_base[0]);
    endproperty
    a_fixed_bits: assert property (p_fixed_bits)
        else $error("fixed vector bits altered");

    property p_idle_code;
        @(posedge core_clk) disable iff (rst)
        read_vec && !ack_start && status_modifies_vector && pend == 6'h00
        |=> data_out[3:1] == 3'h3;
    endproperty
    a_idle_code: assert property (p_idle_code)
        else $error("idle modified vector is not 011");

    property p_chan_a_quiet;
        @(posedge core_clk) disable iff (rst)
        host_bus.rd && !host_bus.chan_b && !ack |=> !data_oe;
    endproperty
    a_chan_a_quiet: assert property (p_chan_a_quiet)
        else $error("data driven on channel A access");

    property p_request;
        @(posedge core_clk) disable iff (rst)
        chain_priority_in && req_any |=> !int_req_n ##1 1'b1;
    endproperty
    a_request: assert property (p_request)
        else $error("interrupt request not asserted");

    property p_pass;
        @(posedge core_clk) disable iff (rst)
        (pend | ius) == 6'h00 |=> chain_priority_out == $past(chain_priority_in);
    endproperty
    a_pass: assert property (p_pass)
        else $error("idle device does not pass chain level");

    property p_block;
        @(posedge core_clk) disable iff (rst)
        ius != 6'h00 |=> !chain_priority_out;
    endproperty
    a_block: assert property (p_block)
        else $error("chain output high while in service");

    property p_freeze;
        @(posedge core_clk) disable iff (rst)
        fetch ##1 fetch |-> $stable(pend);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("pending status changed during opcode fetch");

    sequence s_ack_win;
        ack_start && win_any;
    endsequence
    property p_ack;
        @(posedge core_clk) disable iff (rst)
        s_ack_win |=> data_oe && ((ius & $past(win)) == $past(win));
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge did not drive vector or set latch");

    property p_fetch_no_ack;
        @(posedge core_clk) disable iff (rst)
        plain && !read_vec && !ack_q |=> !data_oe;
    endproperty
    a_fetch_no_ack: assert property (p_fetch_no_ack)
        else $error("plain fetch treated as acknowledge");

    sequence s_return;
        fetch_end && prefix_seen && op_byte == `SCIDC_OP_RETURN &&
            chain_priority_in;
    endsequence
    property p_return;
        @(posedge core_clk) disable iff (rst)
        s_return and !ack_start |=>
            ius == ($past(ius) & ~top_one($past(ius)));
    endproperty
    a_return: assert property (p_return)
        else $error("return did not clear top in-service latch");

    property p_cmd_return;
        @(posedge core_clk) disable iff (rst)
        host_bus.return_cmd && !ack_start && ius != 6'h00 |=>
            $countones(ius) == $countones($past(ius)) - 1;
    endproperty
    a_cmd_return: assert property (p_cmd_return)
        else $error("return command did not clear a latch");

    property p_prefix_chain;
        @(posedge core_clk) disable iff (rst)
        prefix_seen && ius == 6'h00 && chain_priority_in |=>
            chain_priority_out;
    endproperty
    a_prefix_chain: assert property (p_prefix_chain)
        else $error("pending interrupt not forced high after prefix");

endmodule

/* File: verification/scidc_host_model.sv */
// ************************************************************
// host cpu side: acknowledge cycles and opcode fetches
// ************************************************************
module scidc_host_model
    import scidc_pkg::*;
(
    input wire logic core_clk,
    input wire logic go,
    input wire logic ack,
    input wire logic [7:0] opcode,
    output logic opcode_fetch_cycle_n,
    output logic io_request_n,
    output logic [7:0] data,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt = 3'h0;
    initial begin
        opcode_fetch_cycle_n = 1'b1;
        io_request_n = 1'b1;
        data = 8'h00;
        busy = 1'b0;
    end
    // two sampled cycles low, then release with the bus inverted
    always @(posedge core_clk) begin
        if (go && cnt == 3'h0) begin
            cnt <= 3'h3;
            busy <= 1'b1;
            opcode_fetch_cycle_n <= 1'b0;
            io_request_n <= !ack;
            data <= opcode;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h2) begin
                opcode_fetch_cycle_n <= 1'b1;
                io_request_n <= 1'b1;
                data <= ~data;
            end
            if (cnt == 3'h1) begin
                busy <= 1'b0;
            end
        end
    end
endmodule

/* File: verification/scidc_irq_chain_tb_top.sv */
`include "scidc_params.svh"

module scidc_irq_chain_tb_top
    import scidc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0, chan_b = 1'b0, vbw = 1'b0, ret = 1'b0;
    logic go = 1'b0, ack = 1'b0, smv = 1'b0, cin = 1'b1;
    logic [2:0] ptr = 3'h0;
    logic [7:0] wdata = 8'h00, op = 8'h00, m_data, data_out;
    logic [5:0] pend = 6'h00;
    logic m_fetch_n, m_io_request_n_n, m_busy, cout, int_req_n, data_oe;
    logic seen;
    logic [7:0] v;
    scidc_bus_type host_bus;
    int failures = 0;
    int cmp_count = 0;
    logic [2:0] codes [6] = '{`SCIDC_CODE_A_RX, `SCIDC_CODE_A_TX,
        `SCIDC_CODE_A_EXT, `SCIDC_CODE_B_RX, `SCIDC_CODE_B_TX,
        `SCIDC_CODE_B_EXT};

    assign host_bus = '{m_fetch_n, m_io_request_n_n, rd, chan_b, ptr, vbw, ret,
                        m_busy ? m_data : wdata};

    scidc_irq_chain i_scidc_irq_chain (.core_clk(core_clk), .rst(rst),
        .host_bus(host_bus), .status_modifies_vector(smv),
        .src_pending(pend), .chain_priority_in(cin),
        .chain_priority_out(cout), .int_req_n(int_req_n),
        .data_out(data_out), .data_oe(data_oe));
    scidc_host_model i_scidc_host_model (.core_clk(core_clk), .go(go),
        .ack(ack), .opcode(op), .opcode_fetch_cycle_n(m_fetch_n),
        .io_request_n(m_io_request_n_n), .data(m_data), .busy(m_busy));

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    // ************************************************************
    // checking helpers
    // ************************************************************
    task automatic final_report;
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] vec(input logic [2:0] c);
        return (8'ha5 & 8'hf1) | {4'h0, c, 1'b0};
    endfunction
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // ************************************************************
    // bus cycles
    // ************************************************************
    task automatic read_vec(input logic b, input logic [2:0] p,
                            input logic [7:0] exp, input logic answers);
        logic got;
        got = 1'b0;
        @(posedge core_clk);
        rd <= 1'b1;
        chan_b <= b;
        ptr <= p;
        for (int i = 0; i < 4 && !got; i++) begin
            @(negedge core_clk);
            if (data_oe === 1'b1) begin
                got = 1'b1;
                chk_byte(data_out, exp);
            end
        end
        @(posedge core_clk);
        rd <= 1'b0;
        chk_bit(got, answers);
        if (got !== answers && answers) final_report;
    endtask
    task automatic host_cycle(input logic a, input logic [7:0] code);
        seen = 1'b0;
        v = 8'h00;
        @(posedge core_clk);
        go <= 1'b1;
        ack <= a;
        op <= code;
        @(posedge core_clk);
        go <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk);
            if (data_oe === 1'b1 && !seen) begin
                seen = 1'b1;
                v = data_out;
            end
            if (m_busy === 1'b0) break;
        end
        if (m_busy !== 1'b0) begin
            failures++;
            final_report;
        end
    endtask
    task automatic pulse(input logic is_ret);
        @(posedge core_clk);
        vbw <= !is_ret;
        ret <= is_ret;
        wdata <= 8'ha5;
        @(posedge core_clk);
        vbw <= 1'b0;
        ret <= 1'b0;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_readback;
        pulse(1'b0);
        pend <= 6'h01;
        read_vec(1'b1, `SCIDC_PTR_VEC, 8'ha5, 1'b1);
        read_vec(1'b0, `SCIDC_PTR_VEC, 8'h00, 1'b0);
        read_vec(1'b1, 3'h1, 8'h00, 1'b0);
        smv <= 1'b1;
        pend <= 6'h00;
        read_vec(1'b1, `SCIDC_PTR_VEC, 8'ha7, 1'b1);
        for (int i = 0; i < 6; i++) begin
            pend <= 6'h3f << i;
            read_vec(1'b1, `SCIDC_PTR_VEC, vec(codes[i]), 1'b1);
        end
        pend <= 6'h00;
    endtask
    task automatic t_chain;
        @(posedge core_clk);
        pend <= 6'h10;
        settle(3);
        chk_bit(cout, 1'b0);
        chk_bit(int_req_n, 1'b0);
        @(posedge core_clk);
        cin <= 1'b0;
        settle(3);
        chk_bit(int_req_n, 1'b1);
        host_cycle(1'b1, 8'h00);
        chk_bit(seen, 1'b0);
        @(posedge core_clk);
        cin <= 1'b1;
        host_cycle(1'b0, 8'h00);
        chk_bit(seen, 1'b0);
        @(posedge core_clk);
        pend <= 6'h01;
        host_cycle(1'b0, `SCIDC_OP_PREFIX);
        settle(3);
        chk_bit(cout, 1'b1);
        host_cycle(1'b0, 8'h00);
        settle(3);
        chk_bit(cout, 1'b0);
        @(posedge core_clk);
        pend <= 6'h10;
    endtask
    task automatic t_nest;
        host_cycle(1'b1, 8'h00);
        chk_bit(seen, 1'b1);
        chk_byte(v, vec(`SCIDC_CODE_B_TX));
        @(posedge core_clk);
        pend <= 6'h04;
        settle(3);
        chk_bit(int_req_n, 1'b0);
        host_cycle(1'b1, 8'h00);
        chk_byte(v, vec(`SCIDC_CODE_A_EXT));
        @(posedge core_clk);
        pend <= 6'h00;
        host_cycle(1'b0, `SCIDC_OP_PREFIX);
        host_cycle(1'b0, `SCIDC_OP_RETURN);
        @(posedge core_clk);
        pend <= 6'h04;
        settle(3);
        chk_bit(int_req_n, 1'b0);
        chk_bit(cout, 1'b0);
        @(posedge core_clk);
        pend <= 6'h00;
        pulse(1'b1);
        settle(3);
        chk_bit(cout, 1'b1);
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        settle(2);
        chk_bit(cout, 1'b1);
        t_readback;
        t_chain;
        t_nest;
        final_report;
    end
endmodule
